// File: ssp_i2s_params.svh
// register map, field positions, reset values and timing of the i2s port
`ifndef SSP_I2S_PARAMS_SVH
`define SSP_I2S_PARAMS_SVH
// ==========================================================
// register byte offsets
`define OFS_CTRL0   8'h00
`define OFS_CTRL1   8'h04
`define OFS_FMT     8'h08
`define OFS_TXSLOT  8'h0C
`define OFS_RXSLOT  8'h10
`define OFS_STATUS  8'h14
`define OFS_DATA    8'h18
// ==========================================================
// control_reg_zero fields
`define C0_ENABLE   0
`define C0_NETMODE  1
`define C0_FORMAT   2
`define C0_EXTSIZE  4
`define C0_SIZE     5
`define C0_SLOTS    9
`define FMT_PSP     2'h3
// control_reg_one fields
`define C1_CLKDIR   0
`define C1_FRMDIR   1
// frame_format_reg fields
`define FF_WIDTH    0
`define FF_POL      6
`define FF_FRAME_SYNC_TIMING     7
`define FF_SERIAL_CLOCK_MODE   8
`define FF_IDLE     10
`define FF_IDLEEXT  12
`define FF_LEAD     15
`define FF_FDLY     17
`define FF_SDLY     24
// status fields
`define ST_UNDERRUN 0
`define ST_OVERRUN  1
`define ST_BUSY     2
`define ST_TXLVL    8
`define ST_RXLVL    16
// ==========================================================
// reset values
`define RST_CTRL0   12'h000
`define RST_CTRL1   2'h0
`define RST_FMT     27'h0000000
`define RST_SLOT    8'h00
// ==========================================================
// timing
`define SYS_CLK_NS  40
`define BCLK_NS     320
`define BCLK_HALF   (`BCLK_NS / (2 * `SYS_CLK_NS))
`endif

// File: ssp_i2s_pkg.sv
// shared types of the i2s port
package ssp_i2s_pkg;
    typedef logic [1:0] htrans_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_DONE} busPhase_t;
    typedef enum logic {LINK_IDLE, LINK_RUN} linkState_t;
endpackage

// File: bit_sync.sv
// two flip-flop synchroniser for one pin level
`timescale 1ns/1ps
module bit_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    // level in and out
    input  wire logic din,
    output logic      dout
);
    typedef struct packed {
        logic first;
        logic second;
    } syncState_t;
    syncState_t s_q;
    syncState_t s_d;

    always_comb
    begin
        s_d.first  = din;
        s_d.second = s_q.first;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign dout = s_q.second;
endmodule // bit_sync

// File: sample_fifo.sv
// small sample fifo whose head word comes out of a register
`timescale 1ns/1ps
module sample_fifo #(
    parameter int W  = 32,
    parameter int AW = 3
) (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rst,
    // write side
    input  wire logic          push,
    input  wire logic [W-1:0]  wdata,
    output logic               full,
    // read side
    input  wire logic          pop,
    output logic [W-1:0]       head,
    output logic               empty,
    output logic [AW:0]        level
);
    typedef struct packed {
        logic [(1<<AW)-1:0][W-1:0] mem;
        logic [AW:0]               wrPtr;
        logic [AW:0]               rdPtr;
        logic [W-1:0]              head;
    } fifoState_t;
    fifoState_t s_q;
    fifoState_t s_d;

    assign level = s_q.wrPtr - s_q.rdPtr;
    assign full  = (level == (AW+1)'(1 << AW));
    assign empty = (level == '0);
    assign head  = s_q.head;

    always_comb
    begin
        s_d = s_q;
        if (push && !full)
        begin
            s_d.mem[s_q.wrPtr[AW-1:0]] = wdata;
            s_d.wrPtr = s_q.wrPtr + 1'b1;
        end
        if (pop && !empty)
            s_d.rdPtr = s_q.rdPtr + 1'b1;
        // head follows the next state so it never lags the pointers
        s_d.head = s_d.mem[s_d.rdPtr[AW-1:0]];
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s_q <= '0;
        else
            s_q <= s_d;
    end
endmodule // sample_fifo

// File: ssp_i2s_port.sv
// i2s emulation on a network-mode serial port with ahb-lite registers
`timescale 1ns/1ps
`include "ssp_i2s_params.svh"
module ssp_i2s_port #(
    parameter int FIFO_AW  = 3,
    parameter int CLK_HALF = `BCLK_HALF
) (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                rst,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire ssp_i2s_pkg::htrans_t htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // serial link
    output logic                     serialBitClock,
    output logic                     serialBitClockOe,
    output logic                     frameSignal,
    output logic                     frameSignalOe,
    output logic                     txSerialData,
    input  wire logic                rxSerialData
);
    import ssp_i2s_pkg::*;

    typedef struct packed {
        busPhase_t   bus;
        logic [7:0]  addr;
        logic        wr;
        logic [31:0] hrdata;
        logic        hreadyout;
        logic        hresp;
        logic [11:0] ctrl0;
        logic [1:0]  ctrl1;
        logic [26:0] fmt;
        logic [7:0]  txMask;
        logic [7:0]  rxMask;
        logic        underrun;
        logic        overrun;
        linkState_t  link;
        logic [7:0]  halfCnt;
        logic        sclk;
        logic        frame;
        logic        txd;
        logic        clkOe;
        logic        frameOe;
        logic        started;
        logic        bitValid;
        logic [2:0]  fSlot;
        logic [5:0]  fBit;
        logic [8:0]  fPos;
        logic [2:0]  dSlot;
        logic [5:0]  dBit;
        logic [31:0] txShift;
        logic [31:0] rxShift;
    } state_t;
    state_t s_q;
    state_t s_d;

    // ==========================================================
    // fifos and pin synchroniser
    logic               txPush;
    logic               txPop;
    logic               txEmpty;
    logic               txFull;
    logic [31:0]        txHead;
    logic [FIFO_AW:0]   txLevel;
    logic               rxPush;
    logic               rxPop;
    logic               rxEmpty;
    logic               rxFull;
    logic [31:0]        rxHead;
    logic [FIFO_AW:0]   rxLevel;
    logic [31:0]        rxWord;
    logic               rxIn;

    sample_fifo #(.W(32), .AW(FIFO_AW)) txFifo (
        .clock (clock),
        .rst   (rst),
        .push  (txPush),
        .wdata (hwdata),
        .full  (txFull),
        .pop   (txPop),
        .head  (txHead),
        .empty (txEmpty),
        .level (txLevel)
    );

    sample_fifo #(.W(32), .AW(FIFO_AW)) rxFifo (
        .clock (clock),
        .rst   (rst),
        .push  (rxPush),
        .wdata (rxWord),
        .full  (rxFull),
        .pop   (rxPop),
        .head  (rxHead),
        .empty (rxEmpty),
        .level (rxLevel)
    );

    bit_sync rxSync (
        .clock (clock),
        .rst   (rst),
        .din   (rxSerialData),
        .dout  (rxIn)
    );

    // ==========================================================
    // decoded configuration
    logic [5:0]  smpBits;
    logic [5:0]  slotLen;
    logic [5:0]  width;
    logic [2:0]  lastSlot;
    logic        pol;
    logic        frame_sync_timing;
    logic        active;
    logic [31:0] loadVal;
    logic        fallEvt;
    logic        loadEvt;
    logic        newFrame;
    logic [31:0] rdWord;

    assign smpBits  = {1'b0, s_q.ctrl0[`C0_EXTSIZE],
                      s_q.ctrl0[`C0_SIZE +: 4]} + 6'd1;
    assign slotLen  = smpBits + {1'b0, s_q.fmt[`FF_IDLEEXT +: 3],
                      s_q.fmt[`FF_IDLE +: 2]};
    assign lastSlot = s_q.ctrl0[`C0_SLOTS +: 3];
    assign width    = s_q.fmt[`FF_WIDTH +: 6];
    assign pol      = s_q.fmt[`FF_POL];
    assign frame_sync_timing     = s_q.fmt[`FF_FRAME_SYNC_TIMING];
    // slave directions are not supported, so they keep the link idle
    assign active   = s_q.ctrl0[`C0_ENABLE] && s_q.ctrl0[`C0_NETMODE]
                   && s_q.ctrl0[`C0_FORMAT +: 2] == `FMT_PSP
                   && !s_q.ctrl1[`C1_CLKDIR]
                   && !s_q.ctrl1[`C1_FRMDIR];
    // short samples are left aligned so the msb still leads
    assign loadVal  = txHead << (7'd32 - {1'b0, smpBits});
    assign rxWord   = {(s_q.dBit == 6'd0) ? 31'h0 : s_q.rxShift[30:0],
                      rxIn};

    always_comb
    begin
        s_d      = s_q;
        txPush   = 1'b0;
        rxPop    = 1'b0;
        txPop    = 1'b0;
        rxPush   = 1'b0;
        fallEvt  = 1'b0;
        loadEvt  = 1'b0;
        newFrame = 1'b0;
        rdWord   = '0;
        // ======================================================
        // bus slave: one wait state on every transfer
        case (s_q.bus)
            BUS_WAIT:
            begin
                s_d.bus       = BUS_DONE;
                s_d.hreadyout = 1'b1;
                if (s_q.wr)
                begin
                    case (s_q.addr)
                        `OFS_CTRL0:  s_d.ctrl0  = hwdata[11:0];
                        `OFS_CTRL1:  s_d.ctrl1  = hwdata[1:0];
                        `OFS_FMT:    s_d.fmt    = hwdata[26:0];
                        `OFS_TXSLOT: s_d.txMask = hwdata[7:0];
                        `OFS_RXSLOT: s_d.rxMask = hwdata[7:0];
                        `OFS_STATUS:
                        begin
                            if (hwdata[`ST_UNDERRUN])
                                s_d.underrun = 1'b0;
                            if (hwdata[`ST_OVERRUN])
                                s_d.overrun = 1'b0;
                        end
                        `OFS_DATA:   txPush = 1'b1;
                        default:     ;
                    endcase
                end
                else
                begin
                    case (s_q.addr)
                        `OFS_CTRL0:  rdWord[11:0] = s_q.ctrl0;
                        `OFS_CTRL1:  rdWord[1:0]  = s_q.ctrl1;
                        `OFS_FMT:    rdWord[26:0] = s_q.fmt;
                        `OFS_TXSLOT: rdWord[7:0]  = s_q.txMask;
                        `OFS_RXSLOT: rdWord[7:0]  = s_q.rxMask;
                        `OFS_STATUS:
                        begin
                            rdWord[`ST_UNDERRUN] = s_q.underrun;
                            rdWord[`ST_OVERRUN]  = s_q.overrun;
                            rdWord[`ST_BUSY]     = (s_q.link == LINK_RUN);
                            rdWord[`ST_TXLVL +: FIFO_AW+1] = txLevel;
                            rdWord[`ST_RXLVL +: FIFO_AW+1] = rxLevel;
                        end
                        `OFS_DATA:
                        begin
                            rdWord = rxHead;
                            rxPop  = !rxEmpty;
                        end
                        default:     ;
                    endcase
                    s_d.hrdata = rdWord;
                end
            end
            default:
            begin
                s_d.bus = BUS_IDLE;
                if (hsel && hready && htrans[1])
                begin
                    s_d.bus       = BUS_WAIT;
                    s_d.addr      = haddr[7:0];
                    s_d.wr        = hwrite;
                    s_d.hreadyout = 1'b0;
                end
            end
        endcase
        s_d.clkOe   = !s_d.ctrl1[`C1_CLKDIR];
        s_d.frameOe = !s_d.ctrl1[`C1_FRMDIR];
        // ======================================================
        // link engine; flag sets come after the clears so they win
        case (s_q.link)
            LINK_RUN:
            begin
                s_d.halfCnt = s_q.halfCnt + 8'd1;
                if (s_q.halfCnt == 8'(CLK_HALF - 1))
                begin
                    s_d.halfCnt = 8'd0;
                    if (s_q.sclk)
                    begin
                        fallEvt = 1'b1;
                        s_d.fBit = s_q.fBit + 6'd1;
                        s_d.fPos = s_q.fPos + 9'd1;
                        if (s_q.fBit == slotLen - 6'd1)
                        begin
                            s_d.fBit = 6'd0;
                            s_d.fSlot = s_q.fSlot + 3'd1;
                            if (s_q.fSlot == lastSlot)
                            begin
                                newFrame  = 1'b1;
                                s_d.fSlot = 3'd0;
                                s_d.fPos  = 9'd0;
                            end
                        end
                        // stopping at a frame boundary; with a one
                        // clock sync delay the last lsb is not sent
                        if (newFrame && !active)
                            s_d.link = LINK_IDLE;
                        else
                        begin
                            s_d.sclk  = 1'b0;
                            s_d.frame = (s_d.fPos < {3'b000, width})
                                      ? pol : !pol;
                            s_d.started  = 1'b1;
                            s_d.bitValid = s_q.started || !frame_sync_timing;
                            s_d.dSlot = frame_sync_timing ? s_q.fSlot : s_d.fSlot;
                            s_d.dBit  = frame_sync_timing ? s_q.fBit : s_d.fBit;
                            s_d.txShift = {s_q.txShift[30:0], 1'b0};
                            if (s_d.bitValid && s_d.dBit == 6'd0)
                            begin
                                s_d.txShift = '0;
                                if (s_q.txMask[s_d.dSlot])
                                begin
                                    loadEvt = 1'b1;
                                    if (txEmpty)
                                        s_d.underrun = 1'b1;
                                    else
                                    begin
                                        txPop = 1'b1;
                                        s_d.txShift = loadVal;
                                    end
                                end
                            end
                            s_d.txd = s_d.bitValid
                                   && s_d.dBit < smpBits
                                   && s_d.txShift[31];
                        end
                    end
                    else
                    begin
                        s_d.sclk = 1'b1;
                        if (s_q.bitValid && s_q.dBit < smpBits)
                        begin
                            s_d.rxShift = rxWord;
                            if (s_q.dBit == smpBits - 6'd1
                                && s_q.rxMask[s_q.dSlot])
                            begin
                                if (rxFull)
                                    s_d.overrun = 1'b1;
                                else
                                    rxPush = 1'b1;
                            end
                        end
                    end
                end
            end
            default:
            begin
                s_d.sclk     = 1'b1;
                s_d.frame    = !pol;
                s_d.txd      = 1'b0;
                s_d.halfCnt  = 8'd0;
                s_d.started  = 1'b0;
                s_d.bitValid = 1'b0;
                s_d.fSlot    = lastSlot;
                s_d.fBit     = slotLen - 6'd1;
                if (active && !txEmpty)
                    s_d.link = LINK_RUN;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            s_q        <= '0;
            s_q.ctrl0  <= `RST_CTRL0;
            s_q.ctrl1  <= `RST_CTRL1;
            s_q.fmt    <= `RST_FMT;
            s_q.txMask <= `RST_SLOT;
            s_q.rxMask <= `RST_SLOT;
            s_q.sclk   <= 1'b1;
            s_q.frame  <= 1'b1;
            s_q.clkOe  <= 1'b1;
            s_q.frameOe <= 1'b1;
            s_q.hreadyout <= 1'b1;
        end
        else
            s_q <= s_d;
    end

    assign hrdata           = s_q.hrdata;
    assign hreadyout        = s_q.hreadyout;
    assign hresp            = s_q.hresp;
    assign serialBitClock   = s_q.sclk;
    assign serialBitClockOe = s_q.clkOe;
    assign frameSignal      = s_q.frame;
    assign frameSignalOe    = s_q.frameOe;
    assign txSerialData     = s_q.txd;

    // ==========================================================
    // checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_start_needs_data: assert property (
        $rose(s_q.link == LINK_RUN) |-> $past(!txEmpty && active))
        else $error("link started without data or mode");
    a_underrun_sets: assert property (
        (loadEvt && txEmpty) |=> s_q.underrun)
        else $error("underrun flag not set");
    a_frame_wraps: assert property (
        (newFrame && active) |=> s_q.fPos == 9'd0 && s_q.fSlot == 3'd0)
        else $error("frame did not wrap after last slot");
    a_frame_edge: assert property (
        ($fell(s_q.frame) && !pol && $stable(s_q.fmt)
         && s_q.link == LINK_RUN) |-> s_q.fPos == 9'd0)
        else $error("frame went active away from frame start");
    a_sync_delay: assert property (
        (fallEvt && frame_sync_timing && !newFrame && s_q.started)
        |=> s_q.dBit == $past(s_q.fBit))
        else $error("data not one clock behind frame");
    a_msb_aligned: assert property (
        (fallEvt && !frame_sync_timing && s_d.link == LINK_RUN)
        |=> s_q.dBit == s_q.fBit && s_q.dSlot == s_q.fSlot)
        else $error("data not aligned with frame");
    a_drive_on_fall: assert property (
        ($changed(s_q.txd) && $past(s_q.link) == LINK_RUN
         && s_q.link == LINK_RUN) |-> $fell(s_q.sclk))
        else $error("data changed off the falling edge");
    a_rx_push_slot: assert property (
        rxPush |-> s_q.rxMask[s_q.dSlot] && s_q.dBit == smpBits - 6'd1
                   && s_q.sclk == 1'b0)
        else $error("receive push outside active slot end");
    a_tx_msb_first: assert property (
        txPop |=> s_q.txd == $past(loadVal[31]) && !s_q.sclk)
        else $error("first bit out is not the msb");
    a_no_idle_bits: assert property (
        (fallEvt && s_q.fmt[`FF_IDLE +: 2] == 2'b00
         && s_q.fmt[`FF_IDLEEXT +: 3] == 3'b000)
        |=> s_q.dBit < smpBits)
        else $error("idle clock inserted in slot");
    a_master_pins: assert property (
        (!s_q.ctrl1[`C1_CLKDIR] && !s_q.ctrl1[`C1_FRMDIR])
        |=> s_q.clkOe && s_q.frameOe)
        else $error("master pins not driven");

    c_first_frame: cover property ($rose(s_q.link == LINK_RUN));
    c_underrun:    cover property (loadEvt && txEmpty);
    c_rx_slot_one: cover property (rxPush && s_q.dSlot == 3'd1);
    c_delayed:     cover property (fallEvt && frame_sync_timing && s_q.started);
endmodule // ssp_i2s_port

// File: i2s_codec_model.sv
// behavioural codec: records words sent by the port, returns a fixed pair
`timescale 1ns/1ps
module i2s_codec_model #(
    parameter logic [31:0] LEFT  = 32'hA5C30F96,
    parameter logic [31:0] RIGHT = 32'h3C5A96E1
) (
    // mode: 1 for msb-justified, 0 for one-clock delayed
    input  wire logic justified,
    // link in
    input  wire logic serialBitClock,
    input  wire logic frameSignal,
    input  wire logic txSerialData,
    // link out
    output logic      rxSerialData
);
    logic [31:0] capWords [0:31];
    logic [31:0] shIn;
    logic [31:0] word;
    logic [31:0] shOut = 32'h0;
    logic        lastFrm = 1'b1;
    logic        chg = 1'b0;
    logic        pend = 1'b0;
    logic        started = 1'b0;
    int          nCap = 0;
    initial rxSerialData = 1'b0;
    // ==========================================================
    // drive after the falling edge; 1 ns lets the frame settle first
    always @(negedge serialBitClock)
    begin
        #1;
        chg = (frameSignal !== lastFrm);
        if (chg)
        begin
            // a frame edge closes the previous slot
            pend = started;
            started = 1'b1;
            lastFrm = frameSignal;
        end
        // justified words lead with their msb at the frame edge
        if (chg && justified)
            shOut = frameSignal ? RIGHT : LEFT;
        rxSerialData = shOut[31];
        shOut = {shOut[30:0], ~shOut[31]};
        if (chg && !justified)
            shOut = frameSignal ? RIGHT : LEFT;
    end
    // ==========================================================
    // sample on the rising edge, msb first
    always @(posedge serialBitClock)
    begin
        word = {shIn[30:0], txSerialData};
        // delayed mode still owes the last bit of the closed slot
        if (pend && nCap < 32)
        begin
            capWords[nCap] = justified ? shIn : word;
            nCap++;
        end
        shIn = word;
        pend = 1'b0;
    end
endmodule // i2s_codec_model

// File: ssp_i2s_port_tb.sv
// testbench: ahb-lite register access and a normal i2s exchange
`timescale 1ns/1ps
`include "ssp_i2s_params.svh"
module ssp_i2s_port_tb;
    import ssp_i2s_pkg::*;
    localparam logic [31:0] RUN  = 32'h000003FF; // 2 slots, 32 bits
    localparam logic [31:0] HOLD = 32'h000003FD; // network mode off
    localparam logic [31:0] FMT  = 32'h000000A0; // width 32, delayed
    localparam logic [31:0] LW   = 32'hA5C30F96;
    localparam logic [31:0] RW   = 32'h3C5A96E1;
    localparam logic [31:0] TXW [0:3] =
        '{32'h80000001, 32'h7FFFFFFE, 32'hC3A50F5A, 32'h0123ABCD};
    logic        clock = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    htrans_t     htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rdVal;
    logic        justified = 1'b0;
    int          base = 0;
    logic        hreadyout, hresp, bck, bckOe, frm, frmOe, txd, rxd;
    int          fails = 0;
    int          cmp_count = 0;
    always #20 clock = ~clock;
    ssp_i2s_port #(.FIFO_AW(3), .CLK_HALF(4)) dut_u (
        .clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .serialBitClock(bck), .serialBitClockOe(bckOe),
        .frameSignal(frm), .frameSignalOe(frmOe), .txSerialData(txd),
        .rxSerialData(rxd));
    i2s_codec_model #(.LEFT(LW), .RIGHT(RW)) codec_u (
        .justified(justified),
        .serialBitClock(bck), .frameSignal(frm), .txSerialData(txd),
        .rxSerialData(rxd));
    // ==========================================================
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fails++;
            $display("FAIL %s expected %h seen %h", nm, e, s);
        end
    endtask
    // one single transfer; address held until hready, then data phase
    task automatic bus(input logic wr, input logic [7:0] ofs,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, ofs};
        hwrite <= wr;
        do @(posedge clock); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rdVal = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // ==========================================================
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        bus(1'b0, `OFS_CTRL0, 32'h0);
        chk("ctrl0 reset", rdVal, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", rdVal, 32'h0);
        bus(1'b1, `OFS_CTRL1, 32'h0);
        bus(1'b1, `OFS_FMT, FMT);
        bus(1'b1, `OFS_TXSLOT, 32'h3);
        bus(1'b1, `OFS_RXSLOT, 32'h3);
        bus(1'b1, `OFS_CTRL0, RUN);
        bus(1'b0, `OFS_FMT, 32'h0);
        chk("format", rdVal, FMT);
        repeat (100) @(posedge clock);
        chk("idle empty", {30'h0, bck, frm}, 32'h3);
        chk("master oe", {30'h0, bckOe, frmOe}, 32'h3);
        // data queued while network mode is off must not start the link
        bus(1'b1, `OFS_CTRL0, HOLD);
        for (int i = 0; i < 4; i++)
            bus(1'b1, `OFS_DATA, TXW[i]);
        repeat (100) @(posedge clock);
        chk("idle no network", {31'h0, bck}, 32'h1);
        bus(1'b1, `OFS_CTRL0, RUN);
        for (int g = 0; g < 5000 && codec_u.nCap < 8; g++)
            @(posedge clock);
        // frames keep coming after the fifo runs dry
        chk("frames", {31'h0, codec_u.nCap >= 8}, 32'h1);
        for (int i = 0; i < 4; i++)
            chk("tx word", codec_u.capWords[i], TXW[i]);
        chk("underrun data", codec_u.capWords[4], 32'h0);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("underrun", {31'h0, rdVal[`ST_UNDERRUN]}, 32'h1);
        bus(1'b0, `OFS_DATA, 32'h0);
        chk("rx left", rdVal, LW);
        bus(1'b0, `OFS_DATA, 32'h0);
        chk("rx right", rdVal, RW);
        // stop at a frame end, then rerun msb-justified
        bus(1'b1, `OFS_CTRL0, HOLD);
        for (int g = 0; g < 400; g++)
        begin
            bus(1'b0, `OFS_STATUS, 32'h0);
            if (!rdVal[`ST_BUSY])
                break;
        end
        chk("stopped", {31'h0, rdVal[`ST_BUSY]}, 32'h0);
        for (int i = 0; i < 8; i++)
            bus(1'b0, `OFS_DATA, 32'h0);
        bus(1'b1, `OFS_STATUS, 32'h1);
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("drained", rdVal & 32'h000F0001, 32'h0);
        // width 32, active low, no sync delay
        bus(1'b1, `OFS_FMT, 32'h00000020);
        justified <= 1'b1;
        bus(1'b1, `OFS_DATA, TXW[2]);
        bus(1'b1, `OFS_DATA, TXW[3]);
        base = codec_u.nCap;
        bus(1'b1, `OFS_CTRL0, RUN);
        // first capture after the restart holds stale bits
        for (int g = 0; g < 3000 && codec_u.nCap < base + 3; g++)
            @(posedge clock);
        chk("msb left tx", codec_u.capWords[base + 1], TXW[2]);
        chk("msb right tx", codec_u.capWords[base + 2], TXW[3]);
        bus(1'b0, `OFS_DATA, 32'h0);
        chk("msb rx left", rdVal, LW);
        bus(1'b0, `OFS_DATA, 32'h0);
        chk("msb rx right", rdVal, RW);
        conclude();
    end
    initial
    begin
        #(40 * 20000);
        fails++;
        $display("FAIL watchdog expected finish seen timeout");
        conclude();
    end
endmodule // ssp_i2s_port_tb
